/* File: hw/mfetc_pkg.sv */
package mfetc_pkg;

	// Clock rates in MHz and the derived symbol bit spacing in mclk cycles.
	localparam int CLK_MHZ = 200;
	localparam int NIBBLE_MHZ = 25;
	localparam int SYMBOL_MHZ = 125;
	localparam int BITS_PER_GROUP = 5;
	localparam int BIT_CYCLES = (CLK_MHZ / SYMBOL_MHZ) < 1 ? 1 : (CLK_MHZ / SYMBOL_MHZ);

	// Code groups of the 4B5B code space.
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_SSD_J = 5'h18;
	localparam logic [4:0] CG_SSD_K = 5'h11;
	localparam logic [4:0] CG_ESD_T = 5'h0d;
	localparam logic [4:0] CG_ESD_R = 5'h07;
	localparam logic [4:0] CG_HALT = 5'h04;

	// Data code groups, indexed by nibble value.
	localparam logic [4:0] CG_DATA [16] = '{
		5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
	};

	// Scrambler width, taps and reset seed.
	localparam int SCR_WIDTH = 11;
	localparam int SCR_TAP_HI = 10;
	localparam int SCR_TAP_LO = 8;
	localparam logic [10:0] SCR_SEED = 11'h7ff;

	// Line-level sequence steps: positive, zero, negative, zero.
	localparam logic [1:0] MLT_POS = 2'h0;
	localparam logic [1:0] MLT_NEG = 2'h2;

	// Transmit side of the nibble interface, timed on the transmit clock.
	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] d;
	} mfetc_mii_tx_t;

	// Receive side of the nibble interface, timed on the receive clock.
	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
	} mfetc_mii_rx_t;

	// Encoder states, one-hot.
	typedef enum logic [5:0] {
		ENC_IDLE = 6'h01,
		ENC_SSD_K = 6'h02,
		ENC_DATA = 6'h04,
		ENC_ESD_R = 6'h08,
		ENC_BYPASS = 6'h10,
		ENC_SSD_J = 6'h20
	} mfetc_enc_state_t;

endpackage

/* File: hw/mfetc_tx_coder.sv */
`timescale 1ns/1ps
// How it works
// - Accept a TXD nibble each TXEN clock.
// - Drive TXCLK as a free-running clock.
// - TXER with TXEN sends invalid symbols; here only at 100 Mb/s and outside bypass.
// - Drive RXD nibble while RXDV high.
// - Drive RXCLK as a free-running clock.
// - RXDV spans frame, excludes end delimiter.
// - Raise RXER at least one clock on error.
// - CRS high while transmit or receive busy; held low in reduced mode.
// - 25 MHz nibbles, 125 MHz serial symbols; here the bits of a group leave one 200 MHz mclk cycle apart.
// - Map each nibble to a code group.
// - First preamble byte becomes J/K pair.
// - Append T/R pair when TXEN falls.
// - Send idles until next packet starts.
// - Selectable bypass of the 4B5B conversion.
// - XOR each code group with scrambler.
// - Shift scrambled groups out serially.
// - Convert serial stream to NRZI.
// - Split NRZI into two alternating outputs.
// - Reduced mode is timed from 50 MHz reference.
// - Use standard data map, idle is 11111.
// - Halt symbol on TXER at 100 Mb/s.
// - Bypass uses TXER as fifth data bit.
// - Bypass uses RXER as fifth data bit.
module mfetc_tx_coder
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire mfetc_pkg::mfetc_mii_tx_t miiTx,
	input wire mfetc_pkg::mfetc_mii_rx_t decRx,
	input wire logic decRxSym4,
	input wire logic encoderBypassMode,
	input wire logic speed100,
	input wire logic reducedMode,
	output logic txClk,
	output logic rxClk,
	output mfetc_pkg::mfetc_mii_rx_t miiRx,
	output logic crs,
	output logic nrziOut,
	output logic mltPos,
	output logic mltNeg
);

	// Advances the scrambler one bit, feedback from stages 11 and 9.
	function automatic logic [10:0] scrStep(input logic [10:0] s);
		scrStep = {s[9:0], s[mfetc_pkg::SCR_TAP_HI] ^ s[mfetc_pkg::SCR_TAP_LO]};
	endfunction

	// Scrambler output bit for the current state.
	function automatic logic scrKey(input logic [10:0] s);
		scrKey = s[mfetc_pkg::SCR_TAP_HI] ^ s[mfetc_pkg::SCR_TAP_LO];
	endfunction

	// Link-domain reset, asserted at once and released on the link clock.
	logic linkRstMeta_n;
	logic linkRst_n;
	always_ff @(posedge linkClk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			linkRstMeta_n <= 1'b0;
			linkRst_n <= 1'b0;
		end
		else
		begin
			linkRstMeta_n <= 1'b1;
			linkRst_n <= linkRstMeta_n;
		end
	end

	// The link clock is the 25 MHz nibble clock, or the 50 MHz reference in reduced mode.
	// Both interface clocks are forwarded from it without gaps.
	assign txClk = linkClk;
	assign rxClk = linkClk;

	// Mode straps come from pins and pass two flops before use.
	logic [2:0] modeMeta;
	logic [2:0] modeSync;
	always_ff @(posedge linkClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			modeMeta <= 3'h0;
			modeSync <= 3'h0;
		end
		else
		begin
			modeMeta <= {reducedMode, speed100, encoderBypassMode};
			modeSync <= modeMeta;
		end
	end

	logic bypass;
	logic fast;
	logic reduced;
	assign bypass = modeSync[0];
	assign fast = modeSync[1];
	assign reduced = modeSync[2];

	// Encoder state and the code group it presents for the current nibble period.
	mfetc_pkg::mfetc_enc_state_t encState;
	mfetc_pkg::mfetc_enc_state_t next_encState;
	logic [4:0] codeGroup;
	logic [4:0] next_codeGroup;
	logic txBusy;

	// Picks the next code group from the nibble, the state and the modes.
	always_comb
	begin
		next_encState = encState;
		next_codeGroup = mfetc_pkg::CG_IDLE;
		unique case (encState)
			mfetc_pkg::ENC_IDLE:
			begin
				if (bypass)
				begin
					next_encState = mfetc_pkg::ENC_BYPASS;
				end
				else if (miiTx.en)
				begin
					next_codeGroup = mfetc_pkg::CG_SSD_J;
					next_encState = mfetc_pkg::ENC_SSD_K;
				end
			end
			mfetc_pkg::ENC_SSD_K:
			begin
				if (miiTx.en)
				begin
					next_codeGroup = mfetc_pkg::CG_SSD_K;
					next_encState = mfetc_pkg::ENC_DATA;
				end
				else
				begin
					next_codeGroup = mfetc_pkg::CG_ESD_T;
					next_encState = mfetc_pkg::ENC_ESD_R;
				end
			end
			mfetc_pkg::ENC_DATA:
			begin
				if (!miiTx.en)
				begin
					next_codeGroup = mfetc_pkg::CG_ESD_T;
					next_encState = mfetc_pkg::ENC_ESD_R;
				end
				else if (miiTx.er && fast)
				begin
					next_codeGroup = mfetc_pkg::CG_HALT;
				end
				else
				begin
					next_codeGroup = mfetc_pkg::CG_DATA[miiTx.d];
				end
			end
			mfetc_pkg::ENC_ESD_R:
			begin
				next_codeGroup = mfetc_pkg::CG_ESD_R;
				next_encState = mfetc_pkg::ENC_IDLE;
			end
			mfetc_pkg::ENC_BYPASS:
			begin
				if (!bypass)
				begin
					next_encState = mfetc_pkg::ENC_IDLE;
				end
				else if (miiTx.en)
				begin
					next_codeGroup = {miiTx.er, miiTx.d};
				end
			end
			default:
			begin
				next_encState = mfetc_pkg::ENC_IDLE;
			end
		endcase
	end

	// Registers the encoder state and its code group once per nibble period.
	always_ff @(posedge linkClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			encState <= mfetc_pkg::ENC_IDLE;
			codeGroup <= mfetc_pkg::CG_IDLE;
		end
		else
		begin
			encState <= next_encState;
			codeGroup <= next_codeGroup;
		end
	end

	// Transmit is busy from the J group through the T group, or in bypass while the enable is high.
	assign txBusy = (encState != mfetc_pkg::ENC_IDLE && encState != mfetc_pkg::ENC_BYPASS)
		|| (encState == mfetc_pkg::ENC_BYPASS && miiTx.en);

	// Hands each code group to the symbol domain with a toggle; the group
	// stays put for a whole nibble period, far longer than the crossing.
	logic grpToggle;
	always_ff @(posedge linkClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			grpToggle <= 1'b0;
		end
		else
		begin
			grpToggle <= ~grpToggle;
		end
	end

	// Receive nibbles leave on the receive clock from flops.
	// In bypass the error line carries the fifth symbol bit.
	always_ff @(posedge linkClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			miiRx <= '0;
		end
		else
		begin
			miiRx.dv <= decRx.dv;
			miiRx.d <= decRx.dv ? decRx.d : 4'h0;
			miiRx.er <= bypass ? decRxSym4 : decRx.er;
		end
	end

	// Carrier sense follows transmit or receive activity.
	// Reduced mode carries no separate carrier line, so it reads low there.
	always_ff @(posedge linkClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			crs <= 1'b0;
		end
		else
		begin
			crs <= ~reduced & (txBusy | decRx.dv);
		end
	end

	// Symbol domain: toggle synchroniser and edge detect behind it.
	logic togMeta;
	logic togSync;
	logic togSeen;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			togMeta <= 1'b0;
			togSync <= 1'b0;
			togSeen <= 1'b0;
		end
		else
		begin
			togMeta <= grpToggle;
			togSync <= togMeta;
			togSeen <= togSync;
		end
	end

	logic grpArrive;
	assign grpArrive = togSync ^ togSeen;

	// Spaces serial bits BIT_CYCLES mclk cycles apart.
	logic [7:0] bitTimer;
	logic bitTick;
	assign bitTick = (bitTimer == 8'(mfetc_pkg::BIT_CYCLES - 1));
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bitTimer <= 8'h00;
		end
		else if (grpArrive || bitTick)
		begin
			bitTimer <= 8'h00;
		end
		else
		begin
			bitTimer <= bitTimer + 8'h01;
		end
	end

	// Scrambler advances five steps as each group loads, one per bit, idle or not.
	logic [10:0] scr;
	logic [10:0] scr1;
	logic [10:0] scr2;
	logic [10:0] scr3;
	logic [10:0] scr4;
	logic [4:0] scrMask;
	assign scr1 = scrStep(scr);
	assign scr2 = scrStep(scr1);
	assign scr3 = scrStep(scr2);
	assign scr4 = scrStep(scr3);
	assign scrMask = {scrKey(scr), scrKey(scr1), scrKey(scr2), scrKey(scr3), scrKey(scr4)};
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scr <= mfetc_pkg::SCR_SEED;
		end
		else if (grpArrive)
		begin
			scr <= scrStep(scr4);
		end
	end

	// Loads each scrambled group and shifts it out, bit 4 first.
	logic [4:0] shiftReg;
	logic [2:0] bitsLeft;
	logic serialBit;
	logic serialStrobe;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shiftReg <= 5'h00;
			bitsLeft <= 3'h0;
			serialBit <= 1'b0;
			serialStrobe <= 1'b0;
		end
		else if (grpArrive)
		begin
			shiftReg <= codeGroup ^ scrMask;
			bitsLeft <= 3'(mfetc_pkg::BITS_PER_GROUP);
			serialStrobe <= 1'b0;
		end
		else if (bitTick && bitsLeft != 3'h0)
		begin
			serialBit <= shiftReg[4];
			shiftReg <= {shiftReg[3:0], 1'b0};
			bitsLeft <= bitsLeft - 3'h1;
			serialStrobe <= 1'b1;
		end
		else
		begin
			serialStrobe <= 1'b0;
		end
	end

	// NRZI toggles on each one bit and holds on each zero bit.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nrziOut <= 1'b0;
		end
		else if (serialStrobe && serialBit)
		begin
			nrziOut <= ~nrziOut;
		end
	end

	// Steps the line level on each NRZI transition.
	logic [1:0] mltStep;
	logic nrziLast;
	logic nrziEdge;
	assign nrziEdge = nrziOut ^ nrziLast;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nrziLast <= 1'b0;
			mltStep <= 2'h1;
		end
		else
		begin
			nrziLast <= nrziOut;
			if (nrziEdge)
			begin
				mltStep <= mltStep + 2'h1;
			end
		end
	end

	// Two drive streams, each carrying every fourth one event.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mltPos <= 1'b0;
			mltNeg <= 1'b0;
		end
		else
		begin
			mltPos <= (mltStep == mfetc_pkg::MLT_POS);
			mltNeg <= (mltStep == mfetc_pkg::MLT_NEG);
		end
	end

endmodule // mfetc_tx_coder

/* File: verif/mfetc_tx_coder_props.sv */
`timescale 1ns/1ps
// Watches the coder's ports for clock, receive, carrier and line relations.
module mfetc_tx_coder_props
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire mfetc_pkg::mfetc_mii_tx_t miiTx,
	input wire mfetc_pkg::mfetc_mii_rx_t decRx,
	input wire logic decRxSym4,
	input wire logic encoderBypassMode,
	input wire logic speed100,
	input wire logic reducedMode,
	input wire logic txClk,
	input wire logic rxClk,
	input wire mfetc_pkg::mfetc_mii_rx_t miiRx,
	input wire logic crs,
	input wire logic nrziOut,
	input wire logic mltPos,
	input wire logic mltNeg
);
	logic [1:0] upCnt;
	logic rdy;

	// Counts link edges so checks wait until the synchronised link reset lifts.
	always_ff @(posedge linkClk or negedge rst_n)
	begin
		if (!rst_n)
			upCnt <= 2'h0;
		else if (upCnt != 2'h3)
			upCnt <= upCnt + 2'h1;
	end
	assign rdy = (upCnt == 2'h3);

	tx_clock_a: assert property (@(posedge mclk) disable iff (!rst_n) txClk == linkClk)
		else $error("transmit clock differs from link clock");
	rx_clock_a: assert property (@(posedge mclk) disable iff (!rst_n) rxClk == linkClk)
		else $error("receive clock differs from link clock");
	rx_data_a: assert property (@(posedge linkClk) disable iff (!rst_n) rdy |=>
		miiRx.dv == $past(decRx.dv) && miiRx.d == ($past(decRx.dv) ? $past(decRx.d) : 4'h0))
		else $error("receive nibble not passed one link clock later");
	rx_error_a: assert property (@(posedge linkClk) disable iff (!rst_n)
		(rdy && !encoderBypassMode) [*4] |=> miiRx.er == $past(decRx.er))
		else $error("receive error not passed");
	rx_sym4_a: assert property (@(posedge linkClk) disable iff (!rst_n)
		(rdy && encoderBypassMode) [*4] |=> miiRx.er == $past(decRxSym4))
		else $error("fifth receive bit not passed in bypass");
	crs_busy_a: assert property (@(posedge linkClk) disable iff (!rst_n)
		(rdy && !reducedMode) [*4] ##0 (miiTx.en || decRx.dv) |-> ##[1:3] crs)
		else $error("carrier missing while busy");
	crs_idle_a: assert property (@(posedge linkClk) disable iff (!rst_n)
		(rdy && !reducedMode && !miiTx.en && !decRx.dv) [*7] |-> !crs)
		else $error("carrier stays up while idle");
	crs_reduced_a: assert property (@(posedge linkClk) disable iff (!rst_n)
		(rdy && reducedMode) [*4] |-> !crs)
		else $error("carrier raised in reduced mode");
	mlt_excl_a: assert property (@(posedge mclk) disable iff (!rst_n) !(mltPos && mltNeg))
		else $error("both line outputs high");
	mlt_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(nrziOut) |-> ##2 ($changed(mltPos) != $changed(mltNeg)))
		else $error("line level did not advance one step");
endmodule // mfetc_tx_coder_props

/* File: verif/mfetc_mac_model.sv */
`timescale 1ns/1ps
// Behavioural MAC that presents nibble frames on the transmit clock.
module mfetc_mac_model
(
	input wire logic txClk,
	output mfetc_pkg::mfetc_mii_tx_t miiTx
);
	initial miiTx = '0;

	// Sends len nibbles and raises the error line on nibble errAt.
	task automatic send(input int len, input int errAt);
		for (int i = 0; i < len; i++)
		begin
			@(posedge txClk);
			#1;
			miiTx.en = 1'b1;
			miiTx.d = 4'(i);
			miiTx.er = (i == errAt);
		end
		@(posedge txClk);
		#1;
		miiTx.en = 1'b0;
		miiTx.er = 1'b0;
		miiTx.d = ~miiTx.d; // Released data never shows the last nibble.
	endtask
endmodule // mfetc_mac_model

/* File: verif/mfetc_tx_coder_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the transmit coder and its nibble interface.
module mfetc_tx_coder_test;
	logic mclk = 1'b0;
	logic linkClk = 1'b0;
	logic rst_n = 1'b0;
	logic encoderBypassMode = 1'b0;
	logic speed100 = 1'b1;
	logic reducedMode = 1'b0;
	logic decRxSym4 = 1'b0;
	mfetc_pkg::mfetc_mii_rx_t decRx = '0;
	mfetc_pkg::mfetc_mii_tx_t miiTx;
	mfetc_pkg::mfetc_mii_rx_t miiRx;
	logic txClk;
	logic rxClk;
	logic crs;
	logic nrziOut;
	logic mltPos;
	logic mltNeg;
	int miscompares = 0;
	int samplesChecked = 0;
	int cycles = 0;

	// Symbol clock, and a link clock offset from it in phase.
	always #2.5 mclk = ~mclk;
	initial
	begin
		#1.7;
		forever #62.5 linkClk = ~linkClk;
	end

	mfetc_tx_coder dut (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk), .miiTx(miiTx),
		.decRx(decRx), .decRxSym4(decRxSym4), .encoderBypassMode(encoderBypassMode),
		.speed100(speed100), .reducedMode(reducedMode), .txClk(txClk), .rxClk(rxClk),
		.miiRx(miiRx), .crs(crs), .nrziOut(nrziOut), .mltPos(mltPos), .mltNeg(mltNeg));
	mfetc_mac_model mac (.txClk(txClk), .miiTx(miiTx));

	// Compares a seen value with the expected one and counts both outcomes.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Waits n link edges and steps just past the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge linkClk);
		#1;
	endtask

	// Checks both interface clocks high after a link rise, and the transmit clock low after a fall.
	task automatic test_clocks();
		repeat (3)
		begin
			tick(1);
			check("txClk", txClk, 1'b1);
			check("rxClk", rxClk, 1'b1);
			@(negedge linkClk);
			#1;
			check("txClkLow", txClk, 1'b0);
		end
		$display("test_clocks done");
	endtask

	// Passes a receive frame with one error nibble and checks each nibble.
	task automatic test_rx_path();
		for (int i = 0; i < 9; i++)
		begin
			decRx.dv = (i < 8);
			decRx.er = (i == 3);
			decRx.d = 4'(i + 5);
			tick(1);
			check("rxDv", miiRx.dv, decRx.dv);
			check("rxD", miiRx.d, decRx.dv ? decRx.d : 4'h0);
			check("rxEr", miiRx.er, decRx.er);
			if (i > 1 && i < 8)
				check("crsRx", crs, 1'b1);
		end
		tick(2);
		check("crsRxEnd", crs, 1'b0);
		$display("test_rx_path done");
	endtask

	// Sends a frame with an error nibble and checks carrier around its tail.
	task automatic test_tx(input logic spd);
		speed100 = spd;
		tick(3);
		mac.send(16, 5);
		check("crsTail", crs, 1'b1);
		tick(6);
		check("crsIdle", crs, 1'b0);
		// One-nibble frame: the enable drops in the second delimiter slot.
		mac.send(1, -1);
		tick(1);
		check("crsShort", crs, 1'b1);
		tick(6);
		check("crsShortIdle", crs, 1'b0);
		$display("test_tx done");
	endtask

	// Bypass mode: fifth receive bit on the error line, raw symbols sent.
	task automatic test_bypass();
		encoderBypassMode = 1'b1;
		tick(4);
		decRxSym4 = 1'b1;
		tick(1);
		check("rxSym4", miiRx.er, 1'b1);
		decRxSym4 = 1'b0;
		tick(1);
		check("rxSym4Low", miiRx.er, 1'b0);
		mac.send(6, 2);
		tick(8);
		encoderBypassMode = 1'b0;
		tick(4);
		$display("test_bypass done");
	endtask

	// Reduced mode keeps carrier low even with receive traffic.
	task automatic test_reduced();
		reducedMode = 1'b1;
		tick(4);
		decRx.dv = 1'b1;
		tick(3);
		check("crsReduced", crs, 1'b0);
		decRx.dv = 1'b0;
		reducedMode = 1'b0;
		tick(4);
		$display("test_reduced done");
	endtask

	// Reference of the transmit line. Each link edge yields one code group from
	// the nibble interface; its five scrambled bits leave well inside one link
	// period, so the line seen at an edge reflects every group before that edge.
	logic [1:0] refWait;
	logic [1:0] refPhase;
	logic [10:0] refScr;
	logic refNrzi;
	logic [1:0] refStep;
	logic [6:0] refNext;
	logic [15:0] refLine;

	// Next phase above the code group: 0 idle, 1 second delimiter, 2 data, 3 end.
	function automatic logic [6:0] refGroup(input logic [1:0] phase,
		input mfetc_pkg::mfetc_mii_tx_t tx, input logic byp, input logic spd);
		refGroup = {2'h0, mfetc_pkg::CG_IDLE};
		if (byp)
		begin
			if (tx.en)
				refGroup = {2'h0, tx.er, tx.d};
		end
		else if (phase == 2'h0)
		begin
			if (tx.en)
				refGroup = {2'h1, mfetc_pkg::CG_SSD_J};
		end
		else if (phase == 2'h3)
			refGroup = {2'h0, mfetc_pkg::CG_ESD_R};
		else if (!tx.en)
			refGroup = {2'h3, mfetc_pkg::CG_ESD_T};
		else if (phase == 2'h1)
			refGroup = {2'h2, mfetc_pkg::CG_SSD_K};
		else if (tx.er && spd)
			refGroup = {2'h2, mfetc_pkg::CG_HALT};
		else
			refGroup = {2'h2, mfetc_pkg::CG_DATA[tx.d]};
	endfunction

	// Scrambles a group bit 4 first, one generator step per bit, and returns
	// the new generator state above the scrambled group.
	function automatic logic [15:0] refScramble(input logic [10:0] s, input logic [4:0] g);
		logic [10:0] st;
		logic [4:0] sg;
		logic key;
		st = s;
		sg = g;
		for (int i = 4; i >= 0; i--)
		begin
			key = st[mfetc_pkg::SCR_TAP_HI] ^ st[mfetc_pkg::SCR_TAP_LO];
			sg[i] = g[i] ^ key;
			st = {st[9:0], key};
		end
		refScramble = {st, sg};
	endfunction

	assign refNext = refGroup(refPhase, miiTx, encoderBypassMode, speed100);
	assign refLine = refScramble(refScr, refNext[4:0]);

	// Checks the line at each link edge, then folds in the group of this edge.
	// The first group leaves on the third link edge after reset lifts.
	always @(posedge linkClk)
	begin
		if (!rst_n)
		begin
			refWait <= 2'h0;
			refPhase <= 2'h0;
			refScr <= mfetc_pkg::SCR_SEED;
			refNrzi <= 1'b0;
			refStep <= 2'h1;
		end
		else if (refWait != 2'h2)
			refWait <= refWait + 2'h1;
		else
		begin
			check("nrziOut", nrziOut, refNrzi);
			check("mltPos", mltPos, refStep == mfetc_pkg::MLT_POS);
			check("mltNeg", mltNeg, refStep == mfetc_pkg::MLT_NEG);
			refPhase <= refNext[6:5];
			refScr <= refLine[15:5];
			refNrzi <= refNrzi ^ (^refLine[4:0]);
			refStep <= refStep + 2'($countones(refLine[4:0]));
		end
	end

	// Cuts a hang short.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	// Main sequence.
	initial
	begin
		repeat (12) @(posedge linkClk);
		#1;
		rst_n = 1'b1;
		tick(5);
		test_clocks();
		test_rx_path();
		test_tx(1'b1);
		test_tx(1'b0);
		test_bypass();
		test_reduced();
		end_of_test();
	end
endmodule // mfetc_tx_coder_test

bind mfetc_tx_coder mfetc_tx_coder_props chk (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk),
	.miiTx(miiTx), .decRx(decRx), .decRxSym4(decRxSym4), .encoderBypassMode(encoderBypassMode),
	.speed100(speed100), .reducedMode(reducedMode), .txClk(txClk), .rxClk(rxClk),
	.miiRx(miiRx), .crs(crs), .nrziOut(nrziOut), .mltPos(mltPos), .mltNeg(mltNeg));
